// *** shared/gpe_regs.svh ***
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH

// register indices; byte address is four times the index
`define GPE_IDX_P0_OUT 5'h00
`define GPE_IDX_P0_IN 5'h01
`define GPE_IDX_P0_EN 5'h02
`define GPE_IDX_P0_ST 5'h03
`define GPE_IDX_P1_OUT 5'h04
`define GPE_IDX_P1_IN 5'h05
`define GPE_IDX_P1_EN 5'h06
`define GPE_IDX_P1_ST 5'h07
`define GPE_IDX_P2_OUT 5'h08
`define GPE_IDX_P2_IN 5'h09
`define GPE_IDX_P3_OUT 5'h0A
`define GPE_IDX_P3_IN 5'h0B
`define GPE_IDX_PIN_SEL 5'h10
`define GPE_IDX_PIN_CFG 5'h11
`define GPE_IDX_ROUTE 5'h12

// pin configuration fields
`define GPE_CFG_OE 0
`define GPE_CFG_PUSHPULL 1
`define GPE_CFG_PULLUP 2
`define GPE_CFG_LOCK 3
`define GPE_CFG_LEVEL 4
`define GPE_CFG_POL 5
`define GPE_CFG_DEB 6

// reset values
`define GPE_RST_CFG_EVT 7'h44
`define GPE_RST_CFG_PLAIN 7'h04
`define GPE_RST_PIN_SEL 7'h00
`define GPE_RST_ROUTE 3'h1
`define GPE_RST_DATA 8'h00

// debounce interval and its cycle count at 25 MHz
`define GPE_DEBOUNCE_NS 16000
`define GPE_CLK_NS 40
`define GPE_DEBOUNCE_CYC ((`GPE_DEBOUNCE_NS + `GPE_CLK_NS - 1) / `GPE_CLK_NS)

`endif

// *** shared/gpe_pkg.sv ***
package gpe_pkg;
  // axi response codes used by the slave
  typedef enum logic [1:0] {
    GPE_RESP_OKAY = 2'b00,
    GPE_RESP_DECERR = 2'b11
  } gpe_resp_t;

  // one pin configuration register
  typedef logic [6:0] gpe_cfg_t;
endpackage : gpe_pkg

// *** src/gpe_debounce.sv ***
`timescale 1ns/1ps
module gpe_debounce #(
  parameter int W = 16,
  parameter int CYC = 400
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);
  localparam int CW = $clog2(CYC + 1);

  initial begin
    if (CYC < 1 || W < 1) $error("gpe_debounce: bad parameters");
  end

  logic [CW-1:0] cnt [0:W-1];

  // a pin only moves once its new level has held for the whole interval
  // pins leave reset with their pull-ups on, so the filter starts at the high idle
  // level; starting low would show a false rising edge once the interval runs out
  always_ff @(posedge aclk) begin
    for (int i = 0; i < W; i++) begin
      if (!aresetn) begin
        cnt[i] <= '0;
        stable[i] <= 1'b1;
      end else if (raw[i] == stable[i]) begin
        cnt[i] <= '0;
      end else if (cnt[i] == CW'(CYC - 1)) begin
        cnt[i] <= '0;
        stable[i] <= raw[i];
      end else begin
        cnt[i] <= cnt[i] + CW'(1);
      end
    end
  end
endmodule : gpe_debounce

// *** src/gpe_event_detect.sv ***
`timescale 1ns/1ps
module gpe_event_detect #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] sig,
  input wire logic [W-1:0] polarity,
  input wire logic [W-1:0] level_mode,
  output logic [W-1:0] hit
);
  logic [W-1:0] prev;

  initial begin
    if (W < 1) $error("gpe_event_detect: bad width");
  end

  // previous sample for edge detection; starts at the pulled-up idle level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= '1;
    end else begin
      prev <= sig;
    end
  end

  // level mode fires while active; edge mode fires on the move into the active level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      hit[i] = (sig[i] == polarity[i]) && (level_mode[i] || (prev[i] != sig[i]));
    end
  end
endmodule : gpe_event_detect

// *** src/gpe_gpio_top.sv ***
`timescale 1ns/1ps
`include "gpe_regs.svh"
// Overview of operation
// - 29 pins: ports 0, 1, 2 of eight bits and port 3 of five.
// - port 0 pins are bidirectional with events driving irq, management, wake requests.
// - port 1 is bidirectional with events, except bit 5 which is output only.
// - ports 2 and 3 are bidirectional and have no event detection.
// - window base is aligned, base compare ignores the offset bits.
// - the low offset bits pick the runtime register in the window.
// - ports 0/1: output, input, enable, w1c status at offsets 00h and 04h.
// - ports 2/3: only output and input registers at 08h/09h and 0Ah/0Bh.
// - every pin has its own seven-bit configuration register.
// - ports 2/3 configuration keeps bits 3-0 only, bits 6-4 read zero.
// - pin select: port in bits 6-4, pin in bits 2-0, resets to zero.
// - config access reaches the selected pin; resets 44h for ports 0/1, 04h else.
// - config bit 5 picks event polarity: 0 falling/low, 1 rising/high.
// - config bit 6 set passes the event input only after a debounce interval.
module gpe_gpio_top #(
  parameter int ADDR_W = 12,
  parameter logic [ADDR_W-1:0] BASE = '0,
  parameter int DEBOUNCE_CYC = `GPE_DEBOUNCE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output gpe_pkg::gpe_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output gpe_pkg::gpe_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [28:0] gpio_in,
  output logic [28:0] gpio_out,
  output logic [28:0] gpio_oe,
  output logic [28:0] gpio_pullup,
  output logic irq,
  output logic system_management_request,
  output logic power_wakeup_request
);
  import gpe_pkg::*;

  localparam int NPIN = 29;
  localparam int NEVT = 16;
  // port 1 bit 5 is output only, so it never detects events
  localparam logic [NEVT-1:0] EVT_CAP = 16'hDFFF;

  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) $error("gpe_gpio_top: ADDR_W out of range");
    if (BASE[6:0] != 7'h00) $error("gpe_gpio_top: BASE not window aligned");
    if (DEBOUNCE_CYC < 1) $error("gpe_gpio_top: DEBOUNCE_CYC below one");
  end

  // register index from a byte address
  function automatic logic [4:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[6:2];
  endfunction : idx_of

  // window hit; offset bits take no part in the compare
  function automatic logic base_hit(input logic [ADDR_W-1:0] a);
    base_hit = (a[ADDR_W-1:7] == BASE[ADDR_W-1:7]);
  endfunction : base_hit

  // ---- axi-lite handshake state ----
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ok;
  logic [4:0] wr_idx;
  logic [7:0] wd;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_ok = wr_fire && base_hit(aw_addr) && w_strb[0];
  assign wr_idx = idx_of(aw_addr);
  assign wd = w_data[7:0];

  // address and data are held independently, so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GPE_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= base_hit(aw_addr) ? GPE_RESP_OKAY : GPE_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---- register storage ----
  logic [7:0] port_out [0:3];
  logic [7:0] evt_en [0:1];
  logic [7:0] evt_st [0:1];
  logic [6:0] pin_sel;
  gpe_cfg_t cfg [0:NPIN-1];
  logic [2:0] route;

  // selected pin from the select register
  logic [2:0] sel_port;
  logic [2:0] sel_pin;
  logic sel_valid;
  logic [4:0] sel_num;

  assign sel_port = pin_sel[6:4];
  assign sel_pin = pin_sel[2:0];
  // reserved port codes and port 3 pins 5-7 reach nothing
  assign sel_valid = (sel_port < 3'd3) || ((sel_port == 3'd3) && (sel_pin < 3'd5));
  assign sel_num = {sel_port[1:0], sel_pin};

  // output data; port 3 keeps only its five pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 4; p++) begin
        port_out[p] <= `GPE_RST_DATA;
      end
    end else if (wr_ok) begin
      if (wr_idx == `GPE_IDX_P0_OUT) begin
        port_out[0] <= wd;
      end else if (wr_idx == `GPE_IDX_P1_OUT) begin
        port_out[1] <= wd;
      end else if (wr_idx == `GPE_IDX_P2_OUT) begin
        port_out[2] <= wd;
      end else if (wr_idx == `GPE_IDX_P3_OUT) begin
        port_out[3] <= {3'b000, wd[4:0]};
      end
    end
  end

  // event enable doubles as the interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_en[0] <= `GPE_RST_DATA;
      evt_en[1] <= `GPE_RST_DATA;
    end else if (wr_ok) begin
      if (wr_idx == `GPE_IDX_P0_EN) begin
        evt_en[0] <= wd;
      end else if (wr_idx == `GPE_IDX_P1_EN) begin
        evt_en[1] <= wd & EVT_CAP[15:8];
      end
    end
  end

  // pin select and routing of pending events to the three requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sel <= `GPE_RST_PIN_SEL;
      route <= `GPE_RST_ROUTE;
    end else if (wr_ok) begin
      if (wr_idx == `GPE_IDX_PIN_SEL) begin
        pin_sel <= {wd[6:4], 1'b0, wd[2:0]};
      end else if (wr_idx == `GPE_IDX_ROUTE) begin
        route <= wd[2:0];
      end
    end
  end

  // per-pin configuration; a locked pin ignores further writes until reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NPIN; i++) begin
        cfg[i] <= (i < NEVT) ? `GPE_RST_CFG_EVT : `GPE_RST_CFG_PLAIN;
      end
    end else if (wr_ok && wr_idx == `GPE_IDX_PIN_CFG && sel_valid) begin
      if (!cfg[sel_num][`GPE_CFG_LOCK]) begin
        if (sel_port >= 3'd2) begin
          cfg[sel_num] <= {3'b000, wd[3:0]};
        end else begin
          cfg[sel_num] <= wd[6:0];
        end
      end
    end
  end

  // ---- event path, ports 0 and 1 only ----
  logic [NEVT-1:0] deb_in;
  logic [NEVT-1:0] ev_src;
  logic [NEVT-1:0] ev_pol;
  logic [NEVT-1:0] ev_lvl;
  logic [NEVT-1:0] ev_hit;
  logic [NEVT-1:0] ev_set;

  gpe_debounce #(
    .W(NEVT),
    .CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(gpio_in[NEVT-1:0]),
    .stable(deb_in)
  );

  // choose filtered or raw input and gather polarity and type per pin
  always_comb begin
    for (int i = 0; i < NEVT; i++) begin
      ev_src[i] = cfg[i][`GPE_CFG_DEB] ? deb_in[i] : gpio_in[i];
      ev_pol[i] = cfg[i][`GPE_CFG_POL];
      ev_lvl[i] = cfg[i][`GPE_CFG_LEVEL];
    end
  end

  gpe_event_detect #(
    .W(NEVT)
  ) u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig(ev_src),
    .polarity(ev_pol),
    .level_mode(ev_lvl),
    .hit(ev_hit)
  );

  // only enabled, event-capable pins record; ports 2 and 3 have no path here
  assign ev_set = ev_hit & {evt_en[1], evt_en[0]} & EVT_CAP;

  // sticky status; a new event in the clearing cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_st[0] <= `GPE_RST_DATA;
      evt_st[1] <= `GPE_RST_DATA;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (wr_ok && wr_idx == (p == 0 ? `GPE_IDX_P0_ST : `GPE_IDX_P1_ST)) begin
          evt_st[p] <= (evt_st[p] & ~wd) | ev_set[p*8 +: 8];
        end else begin
          evt_st[p] <= evt_st[p] | ev_set[p*8 +: 8];
        end
      end
    end
  end

  // each request routed on stays high while any enabled status bit is set
  logic pending;
  assign pending = |({evt_st[1], evt_st[0]} & {evt_en[1], evt_en[0]});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      system_management_request <= 1'b0;
      power_wakeup_request <= 1'b0;
    end else begin
      irq <= pending && route[0];
      system_management_request <= pending && route[1];
      power_wakeup_request <= pending && route[2];
    end
  end

  // ---- pin drive ----
  logic [NPIN-1:0] out_flat;
  assign out_flat = {port_out[3][4:0], port_out[2], port_out[1], port_out[0]};

  // open-drain drives only a low; push-pull drives both levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_out <= '0;
      gpio_oe <= '0;
      gpio_pullup <= '0;
    end else begin
      gpio_out <= out_flat;
      for (int i = 0; i < NPIN; i++) begin
        gpio_oe[i] <= cfg[i][`GPE_CFG_OE] &&
                      (cfg[i][`GPE_CFG_PUSHPULL] || !out_flat[i]);
        gpio_pullup[i] <= cfg[i][`GPE_CFG_PULLUP];
      end
    end
  end

  // ---- read path ----
  // input view; the output-only pin reads back what it drives
  logic [NPIN-1:0] in_view;
  always_comb begin
    in_view = gpio_in;
    in_view[13] = port_out[1][5];
  end

  function automatic logic [7:0] rd_value(input logic [4:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i == `GPE_IDX_P0_OUT) begin
      v = port_out[0];
    end else if (i == `GPE_IDX_P0_IN) begin
      v = in_view[7:0];
    end else if (i == `GPE_IDX_P0_EN) begin
      v = evt_en[0];
    end else if (i == `GPE_IDX_P0_ST) begin
      v = evt_st[0];
    end else if (i == `GPE_IDX_P1_OUT) begin
      v = port_out[1];
    end else if (i == `GPE_IDX_P1_IN) begin
      v = in_view[15:8];
    end else if (i == `GPE_IDX_P1_EN) begin
      v = evt_en[1];
    end else if (i == `GPE_IDX_P1_ST) begin
      v = evt_st[1];
    end else if (i == `GPE_IDX_P2_OUT) begin
      v = port_out[2];
    end else if (i == `GPE_IDX_P2_IN) begin
      v = in_view[23:16];
    end else if (i == `GPE_IDX_P3_OUT) begin
      v = port_out[3];
    end else if (i == `GPE_IDX_P3_IN) begin
      v = {3'b000, in_view[28:24]};
    end else if (i == `GPE_IDX_PIN_SEL) begin
      v = {1'b0, pin_sel};
    end else if (i == `GPE_IDX_PIN_CFG) begin
      v = sel_valid ? {1'b0, cfg[sel_num]} : 8'h00;
    end else if (i == `GPE_IDX_ROUTE) begin
      v = {5'b00000, route};
    end
    rd_value = v;
  endfunction : rd_value

  // read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= GPE_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      if (base_hit(s_axi_araddr)) begin
        s_axi_rdata <= {24'h000000, rd_value(idx_of(s_axi_araddr))};
        s_axi_rresp <= GPE_RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= GPE_RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : gpe_gpio_top

// *** verification/gpe_gpio_monitor.sv ***
`timescale 1ns/1ps
// protocol and pin checks on the gpio block ports
module gpe_gpio_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [28:0] gpio_out,
  input wire logic [28:0] gpio_oe,
  input wire logic irq,
  input wire logic system_management_request,
  input wire logic power_wakeup_request
);
  import gpe_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write taken without response");
  property p_bvalid_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bvalid_once: assert property (p_bvalid_once)
    else $error("write response repeated");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read taken without data");
  property p_read_block;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_read_block: assert property (p_read_block)
    else $error("read data repeated after it was taken");
  property p_rdata_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_byte: assert property (p_rdata_byte)
    else $error("read data upper bits set");
  property p_reset_quiet;
    $rose(aresetn) |-> gpio_oe == 29'h0 && !irq && !system_management_request
      && !power_wakeup_request;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  // the interrupt only drops after a register write landed
  property p_irq_fall;
    $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
      || !$past(aresetn);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
  property p_out_change;
    !$stable(gpio_out) |-> s_axi_bvalid || $past(s_axi_bvalid) || !$past(aresetn);
  endproperty
  a_out_change: assert property (p_out_change)
    else $error("pin output moved without a write");
  property p_oe_change;
    !$stable(gpio_oe) |-> s_axi_bvalid || $past(s_axi_bvalid) || !$past(aresetn);
  endproperty
  a_oe_change: assert property (p_oe_change)
    else $error("pin enable moved without a write");
endmodule : gpe_gpio_monitor

bind gpe_gpio_top gpe_gpio_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq(irq),
  .system_management_request(system_management_request),
  .power_wakeup_request(power_wakeup_request)
);

// *** verification/gpe_pin_model.sv ***
`timescale 1ns/1ps
// the board around the 29 pins
module gpe_pin_model (
  input wire logic aclk,
  input wire logic [28:0] gpio_out,
  input wire logic [28:0] gpio_oe,
  input wire logic [28:0] gpio_pullup,
  input wire logic [28:0] ext_level,
  input wire logic [28:0] ext_en,
  output logic [28:0] gpio_in
);
  logic [28:0] float_val = 29'h0;
  // a pin nobody drives and nothing pulls wanders, so no stale level survives
  always @(posedge aclk) begin
    float_val <= ~float_val;
  end
  // the block's driver wins, then the outside driver, then the pull-up
  always_comb begin
    gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_en & ext_level)
      | (~gpio_oe & ~ext_en & (gpio_pullup | float_val));
  end
endmodule : gpe_pin_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`include "gpe_regs.svh"
module testbench;
  import gpe_pkg::*;
  localparam int DEB = 4;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, smr, pwr;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  gpe_resp_t bresp, rresp;
  logic [28:0] gpio_in, gpio_out, gpio_oe, gpio_pullup, ext_level, ext_en;
  int fail_count, check_count, cyc;
  logic [4:0] in_idx [4] = '{5'h01, 5'h05, 5'h09, 5'h0B};
  logic [4:0] out_idx [4] = '{5'h00, 5'h04, 5'h08, 5'h0A};
  logic [7:0] in_exp [4] = '{8'h6B, 8'hC9, 8'hA3, 8'h15};

  always #20 aclk = ~aclk;

  gpe_gpio_top #(.ADDR_W(12), .BASE(12'h000), .DEBOUNCE_CYC(DEB)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_pullup(gpio_pullup), .irq(irq),
    .system_management_request(smr), .power_wakeup_request(pwr)
  );
  gpe_pin_model i_pins (
    .aclk(aclk), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pullup(gpio_pullup),
    .ext_level(ext_level), .ext_en(ext_en), .gpio_in(gpio_in)
  );

  function automatic logic [11:0] a(input logic [4:0] i);
    return {5'h0, i, 2'b00};
  endfunction : a

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] ad, input logic [7:0] d,
                    input gpe_resp_t er = GPE_RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
  endtask : wr

  // read one register and compare its byte
  task automatic rc(input logic [4:0] idx, input logic [7:0] exp);
    int n;
    @(posedge aclk);
    araddr <= a(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    // a missing answer or an error code can never match a byte value
    chk((rvalid === 1'b1 && rresp === GPE_RESP_OKAY) ? rdata : 32'hFFFFFFFF, {24'h0, exp});
  endtask : rc

  task automatic sel(input logic [2:0] port, input logic [2:0] pin);
    wr(a(`GPE_IDX_PIN_SEL), {1'b0, port, 1'b0, pin});
  endtask : sel

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // hang guard, the whole sequence needs well under 3000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
    ext_level = {5'h15, 8'hA3, 8'hE9, 8'h6B};
    ext_en = '1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`GPE_IDX_PIN_SEL, 8'h00);
    rc(`GPE_IDX_PIN_CFG, 8'h44);
    sel(3'd1, 3'd7);
    rc(`GPE_IDX_PIN_CFG, 8'h44);
    sel(3'd3, 3'd4);
    rc(`GPE_IDX_PIN_CFG, 8'h04);
    chk({3'h0, gpio_pullup}, 32'h1FFFFFFF);
    // input registers follow the pins and ignore writes; port 1 bit 5 is output only
    for (int p = 0; p < 4; p++) begin
      wr(a(in_idx[p]), 8'hFF);
      rc(in_idx[p], in_exp[p]);
    end
    for (int p = 0; p < 4; p++) begin
      wr(a(out_idx[p]), 8'hFF);
      rc(out_idx[p], p == 3 ? 8'h1F : 8'hFF);
    end
    chk({3'h0, gpio_out}, 32'h1FFFFFFF);
    rc(`GPE_IDX_P1_IN, 8'hE9);
    for (int i = 12; i < 16; i++) begin
      wr(a(5'(i)), 8'hFF);
      rc(5'(i), 8'h00);
    end
    wr(12'h800, 8'h55, GPE_RESP_DECERR);
    rc(`GPE_IDX_P0_OUT, 8'hFF);
    // port 2 pin 0 drives its own level over the outside one
    sel(3'd2, 3'd0);
    wr(a(`GPE_IDX_PIN_CFG), 8'h73);
    rc(`GPE_IDX_PIN_CFG, 8'h03);
    ext_level[16] <= 1'b0;
    rc(`GPE_IDX_P2_IN, 8'hA3);
    chk({30'h0, gpio_oe[16], gpio_pullup[16]}, 32'h2);
    // pin 17: open-drain releases a high and drives a low; lock freezes its setting
    sel(3'd2, 3'd1);
    wr(a(`GPE_IDX_PIN_CFG), 8'h09);
    rc(`GPE_IDX_P2_OUT, 8'hFF);
    chk({31'h0, gpio_oe[17]}, 32'h0);
    wr(a(`GPE_IDX_P2_OUT), 8'hFD);
    wr(a(`GPE_IDX_PIN_CFG), 8'h00);
    rc(`GPE_IDX_PIN_CFG, 8'h09);
    chk({30'h0, gpio_oe[17:16]}, 32'h3);
    // a port 3 pin past its fifth reaches no register
    sel(3'd3, 3'd5);
    rc(`GPE_IDX_PIN_CFG, 8'h00);
    // pin 0: default falling edge through the debounce filter
    wr(a(`GPE_IDX_P0_EN), 8'h01);
    wr(a(`GPE_IDX_P0_ST), 8'hFF);
    ext_level[0] <= 1'b0;
    rc(`GPE_IDX_P0_ST, 8'h00);
    repeat (DEB + 8) @(posedge aclk);
    rc(`GPE_IDX_P0_ST, 8'h01);
    chk({31'h0, irq}, 32'h1);
    for (int r = 0; r < 3; r++) begin
      wr(a(`GPE_IDX_ROUTE), 8'(1 << r));
      repeat (3) @(posedge aclk);
      chk({29'h0, pwr, smr, irq}, 32'(1 << r));
    end
    wr(a(`GPE_IDX_ROUTE), 8'h01);
    wr(a(`GPE_IDX_P0_EN), 8'h00);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(a(`GPE_IDX_P0_EN), 8'h01);
    wr(a(`GPE_IDX_P0_ST), 8'h01);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // pin 1: rising edge, no filter
    sel(3'd0, 3'd1);
    wr(a(`GPE_IDX_PIN_CFG), 8'h20);
    wr(a(`GPE_IDX_P0_EN), 8'h03);
    ext_level[1] <= 1'b0;
    repeat (4) @(posedge aclk);
    rc(`GPE_IDX_P0_ST, 8'h00);
    ext_level[1] <= 1'b1;
    repeat (4) @(posedge aclk);
    rc(`GPE_IDX_P0_ST, 8'h02);
    // pin 2: low level keeps setting status through a clear
    sel(3'd0, 3'd2);
    wr(a(`GPE_IDX_PIN_CFG), 8'h10);
    wr(a(`GPE_IDX_P0_EN), 8'h04);
    repeat (3) @(posedge aclk);
    wr(a(`GPE_IDX_P0_ST), 8'h06);
    rc(`GPE_IDX_P0_ST, 8'h04);
    ext_level[2] <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(a(`GPE_IDX_P0_ST), 8'h04);
    rc(`GPE_IDX_P0_ST, 8'h00);
    wr(a(`GPE_IDX_P1_EN), 8'hFF);
    rc(`GPE_IDX_P1_EN, 8'hDF);
    test_done;
  end
endmodule : testbench
